// ### pcde_params.svh
`ifndef PCDE_PARAMS_SVH
`define PCDE_PARAMS_SVH

// Register indices (byte address is four times the index)
`define PCDE_OFS_C_DATA    8'h07
`define PCDE_OFS_D_DATA    8'h08
`define PCDE_OFS_E_DATA    8'h09
`define PCDE_OFS_C_DIR     8'h87
`define PCDE_OFS_D_DIR     8'h88
`define PCDE_OFS_E_CTRL    8'h89
`define PCDE_OFS_ANA_CFG   8'h9F

// Control/status field positions
`define PCDE_BIT_IN_FULL   7
`define PCDE_BIT_OUT_FULL  6
`define PCDE_BIT_OVERRUN   5
`define PCDE_BIT_SLAVE_SEL 4

// Reset values
`define PCDE_RST_DIR8      8'hFF
`define PCDE_RST_DIR3      3'h7
`define PCDE_RST_ANA       3'h0
`define PCDE_RST_LATCH8    8'h00
`define PCDE_RST_LATCH3    3'h0

// Analog config code that makes the fifth-port pins digital
`define PCDE_ANA_DIGITAL   3'h7

// Cycles from strobe release to the done pulse; the flags update one cycle later
`define PCDE_FLAG_LAG      2

`endif

// ### pcde_pkg.sv
package pcde_pkg;

   typedef struct packed {
      logic       timer_en;
      logic       capture_compare_unit_two_en;
      logic       capture_compare_unit_one_en;
      logic       ssp_en;
      logic       usart_en;
      logic [7:0] dir;
      logic [7:0] dout;
   } pcde_periph_t;

   typedef struct packed {
      logic [7:0] dout;
      logic [7:0] oe_n;
   } pcde_pad_t;

   typedef enum logic [2:0] {
      PCDE_ST_IDLE  = 3'h1,
      PCDE_ST_WRITE = 3'h2,
      PCDE_ST_READ  = 3'h4
   } pcde_state_t;

endpackage

// ### pcde_io_cell.sv
`timescale 1ns/1ps
module pcde_io_cell #(
   parameter int W = 8
) (
   input  wire logic         core_clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] latch,
   input  wire logic [W-1:0] dir,
   input  wire logic [W-1:0] ovr_en,
   input  wire logic [W-1:0] ovr_dir,
   input  wire logic [W-1:0] ovr_dout,
   output logic      [W-1:0] dout,
   output logic      [W-1:0] oe_n
);

   logic [W-1:0] dir_eff;
   logic [W-1:0] dout_eff;

   // Enabled function takes the pin over, bit by bit
   assign dir_eff  = (ovr_en & ovr_dir) | (~ovr_en & dir);
   assign dout_eff = (ovr_en & ovr_dout) | (~ovr_en & latch);

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         oe_n <= {W{1'b1}};
         dout <= {W{1'b0}};
      end else begin
         oe_n <= dir_eff;
         dout <= dout_eff;
      end
   end

endmodule

// ### pcde_top.sv
`timescale 1ns/1ps
`include "pcde_params.svh"
// Operation
// [RL1] Third port: eight pins, each direction set by its own direction bit.
// [RL2] An enabled peripheral overrides a third-port pin direction.
// [RL3] Software avoids read-modify-write on third direction during override.
// [RL4] Pin 0-1 timer/unit two, 2 unit one, 3-5 serial, 6-7 USART.
// [RL5] Fourth port: eight pins, each direction set by its direction bit.
// [RL6] Select bit 4 makes fourth port a slave data bus; resets clear.
// [RL7] In slave mode fifth pins 0,1,2 are read, write, chip select.
// [RL8] Chip select low selects the device; high deselects it.
// [RL9] Software sets fifth pins as digital inputs before slave mode.
// [RL10] Fifth-port pins configured analog read back as zero.
// [RL11] Fifth direction bits drive pins even when analog; keep inputs.
// [RL12] After power-on the fifth pins are analog and read zero.
// [RL13] Input full flag, bit 7, read-only, set when a byte waits.
// [RL14] Output full flag, bit 6, set until the external host reads.
// [RL15] Overrun flag, bit 5, set by write onto unread byte.
// [RL16] Bit 3 reads zero; bits 2-0 fifth directions, reset to one.
// [RL17] Write strobe release sets input full and interrupt after a lag.
// [RL18] Input full clears only on a CPU read of fourth port.
// [RL19] External read clears output full at once; interrupt after release.
// [RL20] Out of slave mode both full flags are held clear.
// [RL21] Data reads return pins; writes load latch driving output pins.
// [RL22] Any reset sets all direction bits; soft reset keeps latches.
module pcde_top #(
   parameter int FLAG_LAG = `PCDE_FLAG_LAG
) (
   input  wire logic                 core_clk,
   input  wire logic                 rst,
   input  wire logic                 soft_rst,
   input  wire logic [7:0]           avs_address,
   input  wire logic                 avs_read,
   input  wire logic                 avs_write,
   input  wire logic [3:0]           avs_byteenable,
   input  wire logic [31:0]          avs_writedata,
   output logic      [31:0]          avs_readdata,
   output logic                      avs_waitrequest,
   input  wire logic [7:0]           c_pin_in,
   input  wire pcde_pkg::pcde_periph_t c_periph,
   output pcde_pkg::pcde_pad_t       c_pad,
   input  wire logic [7:0]           d_pin_in,
   output pcde_pkg::pcde_pad_t       d_pad,
   input  wire logic [2:0]           e_pin_in,
   output logic      [2:0]           e_dout,
   output logic      [2:0]           e_oe_n,
   output logic      [2:0]           analog_pin_config,
   output logic                      slave_port_irq_flag
);

   // Registers
   logic [7:0]  c_latch_reg;
   logic [7:0]  d_latch_reg;
   logic [2:0]  e_latch_reg;
   logic [7:0]  c_dir_reg;
   logic [7:0]  d_dir_reg;
   logic [2:0]  e_dir_reg;
   logic [2:0]  ana_reg;
   logic        slave_port_select_reg;
   logic        input_full_flag_reg;
   logic        output_full_flag_reg;
   logic        input_overrun_flag_reg;
   logic [7:0]  slave_in_reg;
   logic        ack_reg;
   logic [31:0] rdata_reg;
   logic        irq_reg;
   logic [FLAG_LAG-1:0] wr_sr_reg;
   logic [FLAG_LAG-1:0] rd_sr_reg;
   pcde_pkg::pcde_state_t state_reg;
   pcde_pkg::pcde_state_t state_next;

   // Bus decode
   logic        req;
   logic        rd_acc;
   logic        wr_acc;
   logic        rd_take;
   logic [7:0]  wd;
   logic        hit_c;
   logic        hit_d;
   logic        hit_e;
   logic        hit_cdir;
   logic        hit_ddir;
   logic        hit_ectl;
   logic        hit_ana;
   logic [7:0]  rd_mux;

   // Slave port and pin view
   logic        cs_act;
   logic        wr_act;
   logic        rd_act;
   logic        wr_end;
   logic        rd_end;
   logic        wr_done;
   logic        rd_done;
   logic        e_digital;
   logic [2:0]  e_rd_val;
   logic [7:0]  d_rd_val;
   logic [7:0]  e_ctl_val;
   logic [7:0]  c_ovr_en;
   logic        in_full_next;
   logic        out_full_next;
   logic        overrun_next;

   assign req     = avs_read | avs_write;
   assign avs_waitrequest = req & ~ack_reg;
   assign rd_take = avs_read & ~ack_reg;
   assign rd_acc  = avs_read & ack_reg;
   assign wr_acc  = avs_write & ack_reg & avs_byteenable[0];
   assign wd      = avs_writedata[7:0];

   assign hit_c    = avs_address == `PCDE_OFS_C_DATA;
   assign hit_d    = avs_address == `PCDE_OFS_D_DATA;
   assign hit_e    = avs_address == `PCDE_OFS_E_DATA;
   assign hit_cdir = avs_address == `PCDE_OFS_C_DIR;
   assign hit_ddir = avs_address == `PCDE_OFS_D_DIR;
   assign hit_ectl = avs_address == `PCDE_OFS_E_CTRL;
   assign hit_ana  = avs_address == `PCDE_OFS_ANA_CFG;

   // Fifth port reads zero on analog pins
   assign e_digital = ana_reg == `PCDE_ANA_DIGITAL;
   assign e_rd_val  = e_digital ? e_pin_in : 3'h0; // [RL10] [RL12]

   // Slave mode returns the captured byte, else the pins
   assign d_rd_val = slave_port_select_reg ? slave_in_reg
                                           : d_pin_in; // [RL21]

   assign e_ctl_val = {input_full_flag_reg,
                       output_full_flag_reg,
                       input_overrun_flag_reg,
                       slave_port_select_reg,
                       1'b0,
                       e_dir_reg}; // [RL16]

   assign rd_mux = hit_c    ? c_pin_in :
                   hit_d    ? d_rd_val :
                   hit_e    ? {5'h00, e_rd_val} :
                   hit_cdir ? c_dir_reg :
                   hit_ddir ? d_dir_reg :
                   hit_ectl ? e_ctl_val :
                   hit_ana  ? {5'h00, ana_reg} :
                              8'h00;

   assign avs_readdata = rdata_reg;

   // One wait cycle on every access
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ack_reg   <= 1'b0;
         rdata_reg <= 32'h0;
      end else begin
         ack_reg   <= req & ~ack_reg;
         if (rd_take) begin
            rdata_reg <= {24'h000000, rd_mux};
         end
      end
   end

   // Data latches keep their value across soft reset
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         c_latch_reg <= `PCDE_RST_LATCH8;
         d_latch_reg <= `PCDE_RST_LATCH8;
         e_latch_reg <= `PCDE_RST_LATCH3;
      end else if (wr_acc) begin
         if (hit_c) begin
            c_latch_reg <= wd; // [RL21]
         end
         if (hit_d) begin
            d_latch_reg <= wd; // [RL21]
         end
         if (hit_e) begin
            e_latch_reg <= wd[2:0]; // [RL21]
         end
      end
   end

   // Direction and configuration registers
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         c_dir_reg             <= `PCDE_RST_DIR8;
         d_dir_reg             <= `PCDE_RST_DIR8;
         e_dir_reg             <= `PCDE_RST_DIR3;
         ana_reg               <= `PCDE_RST_ANA;
         slave_port_select_reg <= 1'b0;
      end else if (soft_rst) begin
         c_dir_reg             <= `PCDE_RST_DIR8; // [RL22]
         d_dir_reg             <= `PCDE_RST_DIR8; // [RL22]
         e_dir_reg             <= `PCDE_RST_DIR3; // [RL16]
         ana_reg               <= `PCDE_RST_ANA;  // [RL12]
         slave_port_select_reg <= 1'b0;           // [RL6]
      end else if (wr_acc) begin
         if (hit_cdir) begin
            c_dir_reg <= wd; // [RL1] [RL3]
         end
         if (hit_ddir) begin
            d_dir_reg <= wd; // [RL5]
         end
         if (hit_ectl) begin
            e_dir_reg             <= wd[2:0]; // [RL16]
            slave_port_select_reg <= wd[`PCDE_BIT_SLAVE_SEL]; // [RL6]
         end
         if (hit_ana) begin
            ana_reg <= wd[2:0];
         end
      end
   end

   // Strobes only count in slave mode
   assign cs_act = slave_port_select_reg & ~e_pin_in[2]; // [RL7] [RL8]
   assign wr_act = cs_act & ~e_pin_in[1]; // [RL7]
   assign rd_act = cs_act & ~e_pin_in[0]; // [RL7]

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         pcde_pkg::PCDE_ST_IDLE: begin
            if (wr_act) begin
               state_next = pcde_pkg::PCDE_ST_WRITE;
            end else if (rd_act) begin
               state_next = pcde_pkg::PCDE_ST_READ;
            end
         end
         pcde_pkg::PCDE_ST_WRITE: begin
            if (!wr_act) begin
               state_next = pcde_pkg::PCDE_ST_IDLE;
            end
         end
         pcde_pkg::PCDE_ST_READ: begin
            if (!rd_act) begin
               state_next = pcde_pkg::PCDE_ST_IDLE;
            end
         end
         default: begin
            state_next = pcde_pkg::PCDE_ST_IDLE;
         end
      endcase
   end

   assign wr_end = (state_reg == pcde_pkg::PCDE_ST_WRITE) & ~wr_act;
   assign rd_end = (state_reg == pcde_pkg::PCDE_ST_READ) & ~rd_act;
   assign wr_done = wr_sr_reg[FLAG_LAG-1]; // [RL17]
   assign rd_done = rd_sr_reg[FLAG_LAG-1]; // [RL19]

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_reg <= pcde_pkg::PCDE_ST_IDLE;
         wr_sr_reg <= '0;
         rd_sr_reg <= '0;
         irq_reg   <= 1'b0;
      end else if (soft_rst) begin
         state_reg <= pcde_pkg::PCDE_ST_IDLE;
         wr_sr_reg <= '0;
         rd_sr_reg <= '0;
         irq_reg   <= 1'b0;
      end else begin
         state_reg <= state_next;
         wr_sr_reg <= {wr_sr_reg[FLAG_LAG-2:0], wr_end};
         rd_sr_reg <= {rd_sr_reg[FLAG_LAG-2:0], rd_end};
         irq_reg   <= wr_done | rd_done; // [RL17] [RL19]
      end
   end

   assign slave_port_irq_flag = irq_reg;

   // Capture the external byte while the write is active
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         slave_in_reg <= `PCDE_RST_LATCH8;
      end else if (wr_act) begin
         slave_in_reg <= d_pin_in; // [RL6]
      end
   end

   // Every set wins over a clear, except the out-of-slave-mode clear of the full flags
   assign in_full_next =
      !slave_port_select_reg ? 1'b0 :                 // [RL20]
      wr_done                ? 1'b1 :                 // [RL13] [RL17]
      (rd_acc && hit_d)      ? 1'b0 :                 // [RL18]
                               input_full_flag_reg;

   assign out_full_next =
      !slave_port_select_reg ? 1'b0 :                 // [RL20]
      (wr_acc && hit_d)      ? 1'b1 :                 // [RL14]
      (state_reg == pcde_pkg::PCDE_ST_IDLE && rd_act)
                             ? 1'b0 :                 // [RL19]
                               output_full_flag_reg;

   assign overrun_next =
      (wr_done && input_full_flag_reg && slave_port_select_reg)
                             ? 1'b1 :                 // [RL15] [RL18]
      (wr_acc && hit_ectl)   ? wd[`PCDE_BIT_OVERRUN] : // [RL15]
                               input_overrun_flag_reg;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         input_full_flag_reg    <= 1'b0;
         output_full_flag_reg   <= 1'b0;
         input_overrun_flag_reg <= 1'b0;
      end else if (soft_rst) begin
         input_full_flag_reg    <= 1'b0;
         output_full_flag_reg   <= 1'b0;
         input_overrun_flag_reg <= 1'b0;
      end else begin
         input_full_flag_reg    <= in_full_next;
         output_full_flag_reg   <= out_full_next;
         input_overrun_flag_reg <= overrun_next;
      end
   end

   // Peripheral ownership of the third port
   assign c_ovr_en = {c_periph.usart_en,
                      c_periph.usart_en,
                      c_periph.ssp_en,
                      c_periph.ssp_en,
                      c_periph.ssp_en,
                      c_periph.capture_compare_unit_one_en,
                      c_periph.timer_en | c_periph.capture_compare_unit_two_en,
                      c_periph.timer_en}; // [RL4]

   pcde_io_cell #(.W(8)) u_cell_c (
      .core_clk (core_clk),
      .rst      (rst),
      .latch    (c_latch_reg),
      .dir      (c_dir_reg),
      .ovr_en   (c_ovr_en),
      .ovr_dir  (c_periph.dir),
      .ovr_dout (c_periph.dout),
      .dout     (c_pad.dout),
      .oe_n     (c_pad.oe_n)
   ); // [RL1] [RL2]

   // Slave mode ignores the fourth direction register
   pcde_io_cell #(.W(8)) u_cell_d (
      .core_clk (core_clk),
      .rst      (rst),
      .latch    (d_latch_reg),
      .dir      (d_dir_reg),
      .ovr_en   ({8{slave_port_select_reg}}),
      .ovr_dir  ({8{~rd_act}}),
      .ovr_dout (d_latch_reg),
      .dout     (d_pad.dout),
      .oe_n     (d_pad.oe_n)
   ); // [RL5] [RL6]

   pcde_io_cell #(.W(3)) u_cell_e (
      .core_clk (core_clk),
      .rst      (rst),
      .latch    (e_latch_reg),
      .dir      (e_dir_reg),
      .ovr_en   (3'h0),
      .ovr_dir  (3'h7),
      .ovr_dout (3'h0),
      .dout     (e_dout),
      .oe_n     (e_oe_n)
   ); // [RL11]

   assign analog_pin_config = ana_reg;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst || soft_rst);

   a_bus_one_wait: assert property (
      avs_waitrequest |=> !avs_waitrequest)
      else $error("waitrequest held longer than one cycle");

   a_c_dir_drive: assert property ( // [RL1]
      (c_ovr_en == 8'h00) |=> c_pad.oe_n == $past(c_dir_reg))
      else $error("third port enable does not follow direction");

   a_ovr_wins: assert property ( // [RL2]
      c_ovr_en[2] |=> c_pad.oe_n[2] == $past(c_periph.dir[2]))
      else $error("peripheral did not override pin direction");

   a_slave_no_drive: assert property ( // [RL6]
      (slave_port_select_reg && !rd_act) |=> d_pad.oe_n == 8'hFF)
      else $error("fourth port driven without external read");

   a_no_cs_idle: assert property ( // [RL8]
      (e_pin_in[2] && state_reg == pcde_pkg::PCDE_ST_IDLE)
      |=> state_reg == pcde_pkg::PCDE_ST_IDLE)
      else $error("strobe accepted while deselected");

   a_analog_zero: assert property ( // [RL10]
      (rd_take && hit_e && !e_digital) |=> avs_readdata == 32'h0)
      else $error("analog fifth pin read nonzero");

   a_write_sets_full: assert property ( // [RL17]
      (wr_end && slave_port_select_reg) ##FLAG_LAG slave_port_select_reg
      |=> input_full_flag_reg && slave_port_irq_flag)
      else $error("input full not set after write release");

   a_read_clears_full: assert property ( // [RL18]
      (rd_acc && hit_d && !wr_done) |=> !input_full_flag_reg)
      else $error("input full not cleared by CPU read");

   a_overrun_set: assert property ( // [RL15]
      (wr_done && input_full_flag_reg && slave_port_select_reg)
      |=> input_overrun_flag_reg)
      else $error("overrun not flagged");

   a_ext_read_clear: assert property ( // [RL19]
      (state_reg == pcde_pkg::PCDE_ST_IDLE && rd_act && !(wr_acc && hit_d))
      |=> !output_full_flag_reg)
      else $error("output full not cleared on external read");

   a_mode_off_clear: assert property ( // [RL20]
      !slave_port_select_reg |=> !input_full_flag_reg && !output_full_flag_reg)
      else $error("full flags set outside slave mode");

   a_bit3_zero: assert property ( // [RL16]
      (rd_take && hit_ectl) |=> avs_readdata[3] == 1'b0)
      else $error("unimplemented bit reads one");

   c_ext_write:  cover property (wr_done && slave_port_select_reg);
   c_ext_read:   cover property (rd_done && slave_port_select_reg);
   c_overrun:    cover property ($rose(input_overrun_flag_reg));
   c_cpu_load_d: cover property (wr_acc && hit_d && slave_port_select_reg);

endmodule

// ### pcde_host_model.sv
`timescale 1ns/1ps
module pcde_host_model (
   input  wire logic                core_clk,
   input  wire pcde_pkg::pcde_pad_t d_pad,
   input  wire logic [2:0]          e_dout,
   input  wire logic [2:0]          e_oe_n,
   output logic      [7:0]          d_pin,
   output logic      [2:0]          e_pin
);
   logic [7:0] data_reg;
   logic       drv_reg;
   logic [2:0] ctl_reg;
   logic [7:0] bus_w;

   // Released bus shows the inverse of the last byte
   assign bus_w = drv_reg ? data_reg : ~data_reg;
   assign d_pin = (d_pad.dout & ~d_pad.oe_n) | (bus_w & d_pad.oe_n);
   // Strobes {select, write, read}, all active low
   assign e_pin = (e_dout & ~e_oe_n) | (ctl_reg & e_oe_n);

   initial begin
      drv_reg = 1'b0;
      data_reg = 8'h00;
      ctl_reg = 3'h7;
   end

   task automatic set_pins(input logic [7:0] d, input logic [2:0] e);
      drv_reg <= 1'b1;
      data_reg <= d;
      ctl_reg <= e;
   endtask

   task automatic ext_write(input logic [7:0] b, input logic cs_n,
                            input int hold);
      ctl_reg <= {cs_n, 2'b01};
      drv_reg <= 1'b1;
      data_reg <= b;
      repeat (hold) @(posedge core_clk);
      ctl_reg <= 3'h7;
      @(posedge core_clk);
      drv_reg <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic ext_read(output logic [7:0] b, input int hold);
      ctl_reg <= 3'b010;
      drv_reg <= 1'b0;
      repeat (hold) @(posedge core_clk);
      b = d_pin;
      ctl_reg <= 3'h7;
      @(posedge core_clk);
   endtask
endmodule

// ### testbench.sv
`timescale 1ns/1ps
`include "pcde_params.svh"
module testbench;
   localparam int         LAG = 2;
   localparam logic [7:0] MASK [5] = '{8'hC0, 8'h38, 8'h04, 8'h02, 8'h03};
   logic                  core_clk, rst, soft_rst, avs_read, avs_write;
   logic                  avs_waitrequest, irq;
   logic [7:0]            avs_address, c_pin_in, c_ext, d_pin_in;
   logic [3:0]            avs_byteenable;
   logic [31:0]           avs_writedata, avs_readdata;
   pcde_pkg::pcde_periph_t c_periph;
   pcde_pkg::pcde_pad_t   c_pad, d_pad;
   logic [2:0]            e_pin_in, e_dout, e_oe_n, ana_cfg;
   logic [7:0]            cd, cl, ce, dd, dl, de, b1, b2, got;
   int                    error_cnt, checked, irq_cnt, n0;

   assign c_pin_in = (c_pad.dout & ~c_pad.oe_n) | (c_ext & c_pad.oe_n);
   always #2.5 core_clk = ~core_clk;
   always @(posedge core_clk) if (irq === 1'b1) irq_cnt <= irq_cnt + 1;

   pcde_top #(.FLAG_LAG(LAG)) u_dut (
      .core_clk(core_clk), .rst(rst), .soft_rst(soft_rst),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_byteenable(avs_byteenable),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .c_pin_in(c_pin_in),
      .c_periph(c_periph), .c_pad(c_pad), .d_pin_in(d_pin_in),
      .d_pad(d_pad), .e_pin_in(e_pin_in), .e_dout(e_dout),
      .e_oe_n(e_oe_n), .analog_pin_config(ana_cfg),
      .slave_port_irq_flag(irq));
   pcde_host_model u_host (
      .core_clk(core_clk), .d_pad(d_pad), .e_dout(e_dout),
      .e_oe_n(e_oe_n), .d_pin(d_pin_in), .e_pin(e_pin_in));

   function automatic logic [7:0] pins(input logic [7:0] l, d, x);
      return (l & ~d) | (x & d);
   endfunction

   task automatic conclude;
      $display("checked=%0d error_cnt=%0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input logic [7:0] g, input logic [7:0] x);
      checked++;
      if (g !== x) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a, d,
                      output logic [31:0] r);
      int n;
      n = 0;
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= {24'h0, d};
      do begin
         @(posedge core_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 64);
      r = avs_readdata;
      if (avs_waitrequest !== 1'b0) begin
         error_cnt++;
         conclude();
      end
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic wr(input logic [7:0] a, d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask

   task automatic rd(input logic [7:0] a, x);
      logic [31:0] r;
      bus(1'b0, a, 8'h00, r);
      chk(r[7:0], x);
      chk(r[31:24] | r[23:16] | r[15:8], 8'h00);
   endtask

   task automatic settle;
      repeat (3) @(posedge core_clk);
   endtask

   task automatic wait_irq(input int t);
      int n;
      n = 0;
      while (irq_cnt < t && n < 20) begin
         @(posedge core_clk);
         n++;
      end
      settle();
      chk(irq_cnt[7:0], t[7:0]);
   endtask

   initial begin
      core_clk = 1'b0;
      rst = 1'b1;
      soft_rst = 1'b0;
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_byteenable = 4'hF;
      avs_writedata = 32'h0;
      c_ext = 8'h00;
      c_periph = '0;
      error_cnt = 0;
      checked = 0;
      irq_cnt = 0;
      void'($urandom(87484));
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      chk(c_pad.oe_n, 8'hFF);
      rd(`PCDE_OFS_C_DIR, 8'hFF);
      rd(`PCDE_OFS_D_DIR, 8'hFF);
      rd(`PCDE_OFS_E_CTRL, 8'h07);
      rd(`PCDE_OFS_E_DATA, 8'h00);
      rd(8'h40, 8'h00);
      $display("test reset done");
      for (int i = 0; i < 12; i++) begin
         cd = (i < 2) ? {8{i[0]}} : 8'($urandom);
         cl = 8'($urandom);
         ce = 8'($urandom);
         dd = 8'($urandom);
         dl = 8'($urandom);
         de = 8'($urandom);
         c_ext <= ce;
         u_host.set_pins(de, 3'h7);
         wr(`PCDE_OFS_C_DIR, cd);
         wr(`PCDE_OFS_C_DATA, cl);
         wr(`PCDE_OFS_D_DIR, dd);
         wr(`PCDE_OFS_D_DATA, dl);
         settle();
         chk(c_pad.oe_n, cd);
         chk(c_pad.dout & ~cd, cl & ~cd);
         chk(d_pad.oe_n, dd);
         chk(d_pad.dout & ~dd, dl & ~dd);
         rd(`PCDE_OFS_C_DATA, pins(cl, cd, ce));
         rd(`PCDE_OFS_D_DATA, pins(dl, dd, de));
      end
      $display("test gpio done");
      wr(`PCDE_OFS_C_DIR, 8'h5A);
      for (int k = 0; k < 5; k++) begin
         cd = 8'($urandom);
         cl = 8'($urandom);
         c_periph <= {5'h01 << k, cd, cl};
         settle();
         chk(c_pad.oe_n, (8'h5A & ~MASK[k]) | (cd & MASK[k]));
         chk(c_pad.dout & ~cd & MASK[k], cl & ~cd & MASK[k]);
         rd(`PCDE_OFS_C_DIR, 8'h5A);
      end
      c_periph <= '0;
      $display("test override done");
      wr(`PCDE_OFS_ANA_CFG, 8'h07);
      for (int i = 0; i < 6; i++) begin
         cd = {5'h0, 3'($urandom)};
         cl = {5'h0, 3'($urandom)};
         ce = {5'h0, 3'($urandom)};
         u_host.set_pins(8'h00, ce[2:0]);
         wr(`PCDE_OFS_E_CTRL, cd);
         wr(`PCDE_OFS_E_DATA, cl);
         settle();
         chk({5'h0, e_oe_n}, cd);
         rd(`PCDE_OFS_E_DATA, pins(cl, cd, ce));
      end
      wr(`PCDE_OFS_E_CTRL, 8'h0F);
      rd(`PCDE_OFS_E_CTRL, 8'h07);
      wr(`PCDE_OFS_E_CTRL, 8'hC7);
      rd(`PCDE_OFS_E_CTRL, 8'h07);
      wr(`PCDE_OFS_E_CTRL, 8'h27);
      rd(`PCDE_OFS_E_CTRL, 8'h27);
      wr(`PCDE_OFS_E_CTRL, 8'h07);
      wr(`PCDE_OFS_ANA_CFG, 8'h00);
      u_host.set_pins(8'h00, 3'h5);
      settle();
      chk({5'h0, ana_cfg}, 8'h00);
      rd(`PCDE_OFS_E_DATA, 8'h00);
      $display("test fifth done");
      wr(`PCDE_OFS_D_DIR, 8'h00);
      wr(`PCDE_OFS_ANA_CFG, 8'h07);
      u_host.set_pins(8'h00, 3'h7);
      wr(`PCDE_OFS_E_CTRL, 8'h17);
      settle();
      chk(d_pad.oe_n, 8'hFF);
      n0 = irq_cnt;
      u_host.ext_write(8'hA5, 1'b1, 3);
      wait_irq(n0);
      rd(`PCDE_OFS_E_CTRL, 8'h17);
      b1 = 8'($urandom);
      b2 = 8'($urandom);
      u_host.ext_write(b1, 1'b0, 2 + $urandom % 4);
      wait_irq(n0 + 1);
      rd(`PCDE_OFS_E_CTRL, 8'h97);
      u_host.ext_write(b2, 1'b0, 3);
      wait_irq(n0 + 2);
      rd(`PCDE_OFS_E_CTRL, 8'hB7);
      rd(`PCDE_OFS_D_DATA, b2);
      rd(`PCDE_OFS_E_CTRL, 8'h37);
      wr(`PCDE_OFS_E_CTRL, 8'h17);
      rd(`PCDE_OFS_E_CTRL, 8'h17);
      wr(`PCDE_OFS_D_DATA, b1);
      rd(`PCDE_OFS_E_CTRL, 8'h57);
      u_host.ext_read(got, 4 + $urandom % 3);
      chk(got, b1);
      wait_irq(n0 + 3);
      rd(`PCDE_OFS_E_CTRL, 8'h17);
      wr(`PCDE_OFS_D_DATA, b2);
      u_host.ext_write(b1, 1'b0, 2);
      wait_irq(n0 + 4);
      rd(`PCDE_OFS_E_CTRL, 8'hD7);
      wr(`PCDE_OFS_E_CTRL, 8'h07);
      rd(`PCDE_OFS_E_CTRL, 8'h07);
      settle();
      chk(d_pad.oe_n, 8'h00);
      $display("test slave done");
      wr(`PCDE_OFS_C_DIR, 8'h00);
      wr(`PCDE_OFS_C_DATA, 8'h96);
      soft_rst <= 1'b1;
      @(posedge core_clk);
      soft_rst <= 1'b0;
      settle();
      chk(c_pad.oe_n, 8'hFF);
      rd(`PCDE_OFS_C_DIR, 8'hFF);
      rd(`PCDE_OFS_E_CTRL, 8'h07);
      wr(`PCDE_OFS_C_DIR, 8'h00);
      avs_byteenable <= 4'hE;
      wr(`PCDE_OFS_C_DATA, 8'h11);
      avs_byteenable <= 4'hF;
      settle();
      chk(c_pad.dout, 8'h96);
      $display("test soft reset done");
      conclude();
   end

   initial begin
      repeat (50000) @(posedge core_clk);
      error_cnt++;
      conclude();
   end
endmodule
